// ### design/dast_pkg.sv
/*
  dast_pkg: constants for the debug authentication status register block.
  assumes: included before every design file of the block.
*/
package dast_pkg;
  // access decode of the coprocessor read form
  localparam logic [2:0] DAST_OPC1        = 3'h0;
  localparam logic [2:0] DAST_OPC2        = 3'h6;
  localparam logic [3:0] DAST_CRN         = 4'h7;
  localparam logic [3:0] DAST_CRM         = 4'he;
  localparam logic [3:0] DAST_COPROC      = 4'he;
  // field positions
  localparam int         DAST_HYP_NONINVASIVE_FIELD_LSB    = 10;
  localparam int         DAST_HID_LSB     = 8;
  localparam int         DAST_SECURE_NONINVASIVE_FIELD_LSB    = 6;
  localparam int         DAST_SID_LSB     = 4;
  localparam int         DAST_NONSECURE_NONINVASIVE_FIELD_LSB   = 2;
  localparam int         DAST_NONSECURE_INVASIVE_FIELD_LSB    = 0;
  // field codes
  localparam logic [1:0] DAST_CODE_NONE   = 2'h0;
  localparam logic [1:0] DAST_CODE_DIS    = 2'h2;
  localparam logic [1:0] DAST_CODE_EN     = 2'h3;
  // reset value of the output registers
  localparam logic [31:0] DAST_RESET_VAL  = 32'h0000_0000;
  // privilege levels as seen on the access port
  typedef enum logic [1:0] {DAST_LVL_USER, DAST_LVL_KERNEL, DAST_LVL_HYP} dast_level_e;
endpackage : dast_pkg

// ### design/dast_if.sv
/*
  dast_if: bundle of authentication enables passed to the field encoder.
  assumes: one producer (top) and one consumer (encoder), same clock.
*/
`timescale 1ns/1ps
interface dast_if;
  logic hyp_present;
  logic hyp_sep_en;
  logic hyp_nid_en;
  logic hyp_id_en;
  logic ns_nid_en;
  logic ns_id_en;
  logic [31:0] value;
  modport src (output hyp_present, hyp_sep_en, hyp_nid_en, hyp_id_en, ns_nid_en, ns_id_en, input value);
  modport enc (input hyp_present, hyp_sep_en, hyp_nid_en, hyp_id_en, ns_nid_en, ns_id_en, output value);
endinterface : dast_if

// ### design/dast_encode.sv
/*
  dast_encode: combinational encoder from live enables to the register word.
  assumes: enables already synchronised to the processor clock.
*/
`timescale 1ns/1ps
module dast_encode
  import dast_pkg::*;
(
  dast_if.enc a
);
  // hypervisor field: absent level gives 00; a present level always reads the upper bit
  // as one, and without a separate enable it can only report disabled
  function automatic logic [1:0] dast_hfield(input logic present, input logic sep, input logic en);
    logic [1:0] f;
    f = DAST_CODE_NONE;
    if (present)
    begin
      f = (sep && en) ? DAST_CODE_EN : DAST_CODE_DIS;
    end
    return f;
  endfunction : dast_hfield

  // assemble the word, upper bits forced to zero
  always_comb
  begin
    a.value = DAST_RESET_VAL;
    a.value[DAST_HYP_NONINVASIVE_FIELD_LSB +: 2]  = dast_hfield(a.hyp_present, a.hyp_sep_en, a.hyp_nid_en);
    a.value[DAST_HID_LSB +: 2]   = dast_hfield(a.hyp_present, a.hyp_sep_en, a.hyp_id_en);
    a.value[DAST_SECURE_NONINVASIVE_FIELD_LSB +: 2]  = DAST_CODE_NONE;
    a.value[DAST_SID_LSB +: 2]   = DAST_CODE_NONE;
    a.value[DAST_NONSECURE_NONINVASIVE_FIELD_LSB +: 2] = a.ns_nid_en ? DAST_CODE_EN : DAST_CODE_DIS;
    a.value[DAST_NONSECURE_INVASIVE_FIELD_LSB +: 2]  = a.ns_id_en ? DAST_CODE_EN : DAST_CODE_DIS;
  end
endmodule : dast_encode

// ### design/dast_top.sv
/*
  dast_top: read-only debug authentication status register behind a
  coprocessor read port, with hypervisor trap of kernel-level reads.
  assumes: access request is a one-cycle pulse on mclk_i; authentication
  enables come from pins and are synchronised here.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - hypervisor non-invasive field [11:10] is 00 without the level, 10 disabled or without separate enable, 11 enabled.
// - with the hypervisor level present, bit 11 always reads one.
// - with the hypervisor level absent, bits [11:10] read zero.
// - hypervisor invasive field [9:8] is 00 without the level, 10 disabled or without separate enable, 11 enabled.
// - with the hypervisor level present, bit 9 always reads one.
// - with the hypervisor level absent, bits [9:8] read zero.
// - secure non-invasive field [7:6] always reads 00.
// - secure invasive field [5:4] always reads 00.
// - non-secure non-invasive field [3:2] reads 10 when disabled and 11 when enabled.
// - non-secure invasive field [1:0] reads 10 when disabled and 11 when enabled.
// - only a coprocessor read with opc2 110, CRn 0111, CRm 1110 reaches the register; writes do not.
// - with the hypervisor level present and the trap bit set, kernel-level reads trap to hypervisor mode.
module dast_top
  import dast_pkg::*;
#(
  parameter bit HYP_PRESENT = 1'b1,
  parameter bit HYP_SEP_EN  = 1'b1
)
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        acc_valid_i,
  input  wire logic        acc_read_i,
  input  wire logic [3:0]  acc_coproc_i,
  input  wire logic [2:0]  acc_opc1_i,
  input  wire logic [2:0]  acc_opc2_i,
  input  wire logic [3:0]  acc_crn_i,
  input  wire logic [3:0]  acc_crm_i,
  input  wire logic [1:0]  acc_level_i,
  input  wire logic        hyp_debug_access_trap_bit_i,
  input  wire logic        hyp_nid_en_i,
  input  wire logic        hyp_id_en_i,
  input  wire logic        ns_nid_en_i,
  input  wire logic        ns_id_en_i,
  output logic             rd_valid_o,
  output logic [31:0]      rd_data_o,
  output logic             trap_hyp_o,
  output logic             undef_o
);
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       hit;
  logic       trap;
  dast_if     bus ();

  // enables arrive from the authentication pins, two stages each
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {hyp_nid_en_i, hyp_id_en_i, ns_nid_en_i, ns_id_en_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign bus.hyp_present = HYP_PRESENT;
  assign bus.hyp_sep_en  = HYP_SEP_EN;
  assign bus.hyp_nid_en  = sync2_reg[3];
  assign bus.hyp_id_en   = sync2_reg[2];
  assign bus.ns_nid_en   = sync2_reg[1];
  assign bus.ns_id_en    = sync2_reg[0];

  dast_encode u_enc (
    .a (bus.enc)
  );

  // decode: read and write forms both match; a write with the same fields is undefined
  assign hit = acc_valid_i && (acc_coproc_i == DAST_COPROC) && (acc_opc1_i == DAST_OPC1)
            && (acc_opc2_i == DAST_OPC2) && (acc_crn_i == DAST_CRN) && (acc_crm_i == DAST_CRM);
  assign trap = HYP_PRESENT && hyp_debug_access_trap_bit_i
             && (acc_level_i == DAST_LVL_KERNEL);

  // answer one cycle after the request; no state is held behind the word
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= DAST_RESET_VAL;
      trap_hyp_o <= 1'b0;
      undef_o    <= 1'b0;
    end
    else
    begin
      rd_valid_o <= hit && acc_read_i && !trap;
      rd_data_o  <= (hit && acc_read_i && !trap) ? bus.value : DAST_RESET_VAL;
      trap_hyp_o <= hit && acc_read_i && trap;
      undef_o    <= hit && (!acc_read_i || acc_level_i == DAST_LVL_USER) && !(acc_read_i && trap);
    end
  end

  // user-level reads get data and a fault flag; the fault is what software acts on
  logic user_rd;
  assign user_rd = hit && acc_read_i && (acc_level_i == DAST_LVL_USER);

  // upper bits carry no state in any cycle
  a_upper_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_data_o[31:12] == 20'h0)
    else $error("upper bits not zero");

  // hypervisor non-invasive upper bit follows the level being present
  a_hyp_noninvasive_field_upper: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[11] == HYP_PRESENT)
    else $error("hyp_noninvasive_field upper wrong");

  // hypervisor invasive upper bit follows the level being present
  a_hid_upper: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[9] == HYP_PRESENT)
    else $error("hid upper wrong");

  // both hypervisor fields vanish without the level
  a_hyp_absent: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o && !HYP_PRESENT
    |-> rd_data_o[11:8] == 4'h0)
    else $error("hyp fields not zero");

  // secure fields are not implemented
  a_secure_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_data_o[7:4] == 4'h0)
    else $error("secure fields not zero");

  // non-secure fields are always implemented
  a_ns_fields: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[3] && rd_data_o[1])
    else $error("ns fields upper bit clear");

  // invasive field shows the enable seen at the request edge
  a_ns_inv: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && acc_read_i && !trap
    |=> rd_data_o[1:0] == {1'b1, $past(sync2_reg[0])})
    else $error("ns invasive mismatch");

  // trapped reads give no data
  a_trap_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && acc_read_i && trap
    |=> trap_hyp_o && !rd_valid_o)
    else $error("trap missed");

  // the write form never returns data
  a_no_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    acc_valid_i && !acc_read_i
    |=> !rd_valid_o)
    else $error("write answered");

  // separate enable present: never the absent code
  a_hid_code: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o && HYP_PRESENT && HYP_SEP_EN
    |-> rd_data_o[9:8] != 2'h0)
    else $error("hid code");

  // separate enable present: never a reserved code
  a_hyp_noninvasive_field_code: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o && HYP_PRESENT && HYP_SEP_EN
    |-> rd_data_o[11:10] != 2'h1)
    else $error("hyp_noninvasive_field code");

  // reserved invasive code never shows
  a_hid_rsv: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_data_o[9:8] != 2'h1)
    else $error("hid reserved");

  // secure invasive field reads zero
  a_sid_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_data_o[5:4] == 2'h0)
    else $error("sid not zero");

  // secure non-invasive field reads zero
  a_secure_nid: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_data_o[7:6] == 2'h0)
    else $error("secure_noninvasive_field not zero");

  // full hypervisor non-invasive code against the enable at the request edge
  a_hyp_noninvasive_field_value: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[11:10] == (HYP_PRESENT ? {1'b1, HYP_SEP_EN && $past(sync2_reg[3])} : 2'h0))
    else $error("hyp_noninvasive_field value wrong");

  // full hypervisor invasive code against the enable at the request edge
  a_hid_value: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[9:8] == (HYP_PRESENT ? {1'b1, HYP_SEP_EN && $past(sync2_reg[2])} : 2'h0))
    else $error("hid value wrong");

  // non-secure non-invasive code against the enable at the request edge
  a_nonsecure_noninvasive_field_value: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> rd_data_o[3:2] == {1'b1, $past(sync2_reg[1])})
    else $error("nonsecure_noninvasive_field value wrong");

  // absent level: non-invasive field zero in every cycle
  a_hyp_noninvasive_field_absent: assert property (@(posedge mclk_i) disable iff (rst_i)
    !HYP_PRESENT
    |-> rd_data_o[11:10] == 2'h0)
    else $error("hyp_noninvasive_field not zero");

  // absent level: invasive field zero in every cycle
  a_hid_absent: assert property (@(posedge mclk_i) disable iff (rst_i)
    !HYP_PRESENT
    |-> rd_data_o[9:8] == 2'h0)
    else $error("hid not zero");

  // data bus stays quiet between answers
  a_idle_data: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rd_valid_o
    |-> rd_data_o == 32'h0)
    else $error("data without valid");

  // a read is either answered or trapped, never both
  a_one_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(rd_valid_o && trap_hyp_o))
    else $error("answer and trap together");

  // every untrapped matching read is answered next cycle
  a_read_taken: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && acc_read_i && !trap
    |=> rd_valid_o)
    else $error("read not answered");

  // no answer without a matching read the cycle before
  a_valid_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o
    |-> $past(hit && acc_read_i))
    else $error("answer without read");

  // a decode miss leaves every output low
  a_miss_silent: assert property (@(posedge mclk_i) disable iff (rst_i)
    acc_valid_i && !hit
    |=> !rd_valid_o && !trap_hyp_o && !undef_o)
    else $error("miss answered");

  // the write form is faulted, never trapped
  a_write_undef: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && !acc_read_i
    |=> undef_o && !trap_hyp_o)
    else $error("write not faulted");

  // hypervisor-level reads are never trapped
  a_hyp_no_trap: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && acc_read_i && (acc_level_i == DAST_LVL_HYP)
    |=> rd_valid_o && !trap_hyp_o)
    else $error("hyp read trapped");

  // a trap needs the level, the control bit and a kernel requester
  a_trap_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
    trap_hyp_o
    |-> HYP_PRESENT && $past(hyp_debug_access_trap_bit_i && acc_level_i == DAST_LVL_KERNEL))
    else $error("trap without cause");

  // kernel reads pass while the control bit is clear
  a_kernel_open: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && acc_read_i && (acc_level_i == DAST_LVL_KERNEL) && !hyp_debug_access_trap_bit_i
    |=> rd_valid_o)
    else $error("kernel read blocked");

  // user reads are answered and flagged
  a_user_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    user_rd
    |=> undef_o && rd_valid_o)
    else $error("user read not flagged");

  // second sync stage only ever copies the first
  a_sync_stage: assert property (@(posedge mclk_i) disable iff (rst_i)
    sync2_reg == $past(sync1_reg))
    else $error("sync stage skipped");

  // fault flag only after a matching access
  a_undef_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
    undef_o
    |-> $past(hit))
    else $error("fault without access");

  // a faulted read came from the user level
  a_undef_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    undef_o && $past(acc_read_i)
    |-> $past(acc_level_i == DAST_LVL_USER))
    else $error("read fault at wrong level");

  // plain answered read
  c_read: cover property (@(posedge mclk_i) disable iff (rst_i) rd_valid_o);
  // kernel read sent to the hypervisor
  c_trap: cover property (@(posedge mclk_i) disable iff (rst_i) trap_hyp_o);
  // write form or user access faulted
  c_undef: cover property (@(posedge mclk_i) disable iff (rst_i) undef_o);
  // user-level read seen
  c_user: cover property (@(posedge mclk_i) disable iff (rst_i) user_rd);
  // read while invasive debug is enabled
  c_enabled: cover property (@(posedge mclk_i) disable iff (rst_i) rd_valid_o && rd_data_o[1:0] == 2'h3);
endmodule : dast_top

// ### tb/tb_dast_top.sv
/*
  tb_dast_top: self-checking bench for the debug authentication status block.
  assumes: dast_pkg and dast_if compiled first; further instances run one without hypervisor level
  and one without a separate hypervisor enable.
*/
`timescale 1ns/1ps
module tb_dast_top;
  import dast_pkg::*;
  logic        mclk_i = 1'b0, rst_i = 1'b1, acc_valid_i = 1'b0, acc_read_i = 1'b1, trap_bit = 1'b0;
  logic [3:0]  coproc = DAST_COPROC, crn = DAST_CRN, crm = DAST_CRM;
  logic [2:0]  opc1 = DAST_OPC1, opc2 = DAST_OPC2;
  logic [1:0]  lvl = DAST_LVL_KERNEL;
  logic [3:0]  en = 4'h0; // hyp_nid, hyp_id, ns_nid, ns_id
  logic        rv_a, tr_a, ud_a, rv_b, tr_b, ud_b;
  logic [31:0] rd_a, rd_b, rd_c;
  int          err_total = 0, cmp_count = 0;
  // instance with hypervisor level and separate enable
  dast_top #(.HYP_PRESENT(1'b1), .HYP_SEP_EN(1'b1)) dast_top_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .acc_valid_i(acc_valid_i), .acc_read_i(acc_read_i), .acc_coproc_i(coproc), .acc_opc1_i(opc1), .acc_opc2_i(opc2),
    .acc_crn_i(crn), .acc_crm_i(crm), .acc_level_i(lvl), .hyp_debug_access_trap_bit_i(trap_bit), .hyp_nid_en_i(en[3]),
    .hyp_id_en_i(en[2]), .ns_nid_en_i(en[1]), .ns_id_en_i(en[0]), .rd_valid_o(rv_a), .rd_data_o(rd_a),
    .trap_hyp_o(tr_a), .undef_o(ud_a));
  // same stimulus, hypervisor level absent
  dast_top #(.HYP_PRESENT(1'b0), .HYP_SEP_EN(1'b1)) dast_top_b_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .acc_valid_i(acc_valid_i), .acc_read_i(acc_read_i), .acc_coproc_i(coproc), .acc_opc1_i(opc1), .acc_opc2_i(opc2),
    .acc_crn_i(crn), .acc_crm_i(crm), .acc_level_i(lvl), .hyp_debug_access_trap_bit_i(trap_bit), .hyp_nid_en_i(en[3]),
    .hyp_id_en_i(en[2]), .ns_nid_en_i(en[1]), .ns_id_en_i(en[0]), .rd_valid_o(rv_b), .rd_data_o(rd_b),
    .trap_hyp_o(tr_b), .undef_o(ud_b));
  // hypervisor level present without a separate enable: fields read disabled
  dast_top #(.HYP_PRESENT(1'b1), .HYP_SEP_EN(1'b0)) dast_top_c_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .acc_valid_i(acc_valid_i), .acc_read_i(acc_read_i), .acc_coproc_i(coproc), .acc_opc1_i(opc1), .acc_opc2_i(opc2),
    .acc_crn_i(crn), .acc_crm_i(crm), .acc_level_i(lvl), .hyp_debug_access_trap_bit_i(trap_bit), .hyp_nid_en_i(en[3]),
    .hyp_id_en_i(en[2]), .ns_nid_en_i(en[1]), .ns_id_en_i(en[0]), .rd_valid_o(), .rd_data_o(rd_c),
    .trap_hyp_o(), .undef_o());
  always #2.5 mclk_i = ~mclk_i;
  // value comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // one-cycle request launched at a falling edge; answer seen one edge later
  task automatic access(input logic rd, input logic [1:0] lv, input logic [3:0] cp, input logic [2:0] o1,
                        input logic [2:0] o2, input logic [3:0] cn, input logic [3:0] cm);
    @(negedge mclk_i);
    {acc_read_i, lvl, coproc, opc1, opc2, crn, crm} = {rd, lv, cp, o1, o2, cn, cm};
    acc_valid_i = 1'b1;
    @(negedge mclk_i);
    acc_valid_i = 1'b0;
  endtask : access
  // every enable combination; extra cycles cover the two-flop sync
  task automatic test_fields();
    for (int i = 0; i < 16; i++)
    begin
      en = i[3:0];
      repeat (3) @(negedge mclk_i);
      access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
      chk({29'h0, rv_a, tr_a, ud_a}, 32'h4, "read answer");
      chk(rd_a, {20'h0, 1'b1, en[3], 1'b1, en[2], 4'h0, 1'b1, en[1], 1'b1, en[0]}, "word hyp");
      chk(rd_b, {28'h0, 1'b1, en[1], 1'b1, en[0]}, "word nohyp");
      chk(rd_c, {20'h0, 4'ha, 4'h0, 1'b1, en[1], 1'b1, en[0]}, "word no sep");
    end
    @(negedge mclk_i);
    chk({31'h0, rv_a}, 32'h0, "valid stands one cycle");
    $display("test fields done");
  endtask : test_fields
  // kernel reads trap only with hypervisor level and trap bit
  task automatic test_trap();
    trap_bit = 1'b1;
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h2, "kernel trapped");
    chk(rd_a, 32'h0, "no data on trap");
    chk({29'h0, rv_b, tr_b, ud_b}, 32'h4, "no trap without hyp");
    access(1'b1, DAST_LVL_HYP, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h4, "hyp read not trapped");
    trap_bit = 1'b0;
    $display("test trap done");
  endtask : test_trap
  // decode misses give nothing; write form and user reads are faulted
  task automatic test_decode();
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC ^ 4'h1, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h0, "coproc miss");
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1 ^ 3'h1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h0, "opc1 miss");
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2 ^ 3'h1, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h0, "opc2 miss");
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN ^ 4'h1, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h0, "crn miss");
    access(1'b1, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM ^ 4'h1);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h0, "crm miss");
    access(1'b0, DAST_LVL_KERNEL, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h1, "write form");
    chk({29'h0, rv_b, tr_b, ud_b}, 32'h1, "write form nohyp");
    access(1'b1, DAST_LVL_USER, DAST_COPROC, DAST_OPC1, DAST_OPC2, DAST_CRN, DAST_CRM);
    chk({29'h0, rv_a, tr_a, ud_a}, 32'h5, "user read");
    $display("test decode done");
  endtask : test_decode
  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // watchdog: tests need a little over a hundred cycles
  initial
  begin
    #20000;
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    test_fields();
    test_trap();
    test_decode();
    end_sim();
  end
endmodule : tb_dast_top
